/* File: hw/trf_defines.svh */
/*
 Constants of the tablet report flow block: clock and scan rates,
 register offsets and reset values, host command characters.
 Assumes inclusion by bare name from the design and bench files.
*/
`ifndef TRF_DEFINES_SVH
`define TRF_DEFINES_SVH

// Rates in hertz
`define TRF_CLK_HZ      250000000
`define TRF_SCAN_HZ     110
`define TRF_RPS_110     110
`define TRF_RPS_72      72
`define TRF_RPS_36      36
`define TRF_RPS_18      18
`define TRF_RPS_9       9

// Report rate selector codes
`define TRF_RATE_110    3'h0
`define TRF_RATE_72     3'h1
`define TRF_RATE_36     3'h2
`define TRF_RATE_18     3'h3
`define TRF_RATE_9      3'h4

// Register byte offsets, control reset value and alternate-rate bit index
`define TRF_CTRL_OFF    8'h00
`define TRF_STAT_OFF    8'h04
`define TRF_CTRL_RST    3'h0
`define TRF_CTRL_ALT    2

// Host command characters
`define TRF_CMD_POINT   8'h42
`define TRF_CMD_REQ     8'h44
`define TRF_CMD_TRIG    8'h50
`define TRF_CMD_STREAM  8'h40
`define TRF_CMD_SWSTRM  8'h41
`define TRF_CMD_INC     8'h49
`define TRF_CMD_RESET   8'h7e
`define TRF_CMD_R110    8'h51
`define TRF_CMD_R72     8'h52
`define TRF_CMD_R36     8'h56
`define TRF_CMD_R18     8'h53
`define TRF_CMD_R9      8'h54

// Increment argument range and offset
`define TRF_INC_LO      8'h20
`define TRF_INC_HI      8'h7a
`define TRF_INC_OFS     8'h20

// Out-of-range stream repeats
`define TRF_OOP_REP     3'h4

`endif

/* File: hw/trf_pkg.sv */
/*
 Types of the tablet report flow block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package trf_pkg;
    // Report flow modes
    typedef enum logic [1:0] {MODE_POINT, MODE_REQUEST, MODE_STREAM, MODE_SWSTREAM} trf_mode_t;
    // Hardware configuration
    typedef enum logic [1:0] {CFG_NATIVE, CFG_COMPAT1, CFG_COMPAT2, CFG_SPARE} trf_cfg_t;
    // Tool scan from the sensor pins
    typedef struct packed {
        logic        in_range;
        logic [2:0]  button;
        logic [13:0] x;
        logic [13:0] y;
    } trf_tool_t;
    // Three report bytes, b0 sent first
    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
    } trf_frame_t;
endpackage

/* File: hw/trf_report_flow.sv */
/*
 Tablet report flow: scans the tool, decides when to issue relative
 reports, encodes them and hands bytes to a serial transmitter.
 Assumes a UART receiver on aclk giving one-cycle command bytes, a
 transmitter with a valid/ready byte port, and sensor pins that are
 asynchronous to aclk. Registers sit on an AXI4-Lite slave.
*/
`timescale 1ns/1ns
`include "trf_defines.svh"

// Overview of operation
// - Three bytes: header, seven-bit X, seven-bit Y
// - Absolute flags one-hot, button one bit a
// - Relative flags carry button number in binary
// - Sign bit one positive, zero negative
// - Proximity bit low in range, high out
// - Phasing bit of first byte always one
// - First compatibility config resets to streaming
// - Other configs reset to request mode
// - Proximity bit omitted in first compatibility config
// - Scan 110 per second, send per mode
// - Out of range reports last in-range sample
// - Point mode reports on press and release
// - One report per host trigger character
// - First trigger answered fast, 110 per second
// - Streaming sends at report rate regardless
// - Leaving range: repeat four times, then stop
// - Switched streaming while held, zero-flag release
// - Switched, out of range: last sample continuously
// - One character picks rate for streaming modes
// - Default rate 110 or 72 by strap
// - Increment command plus one value character
// - Report when square of twice increment reached
// - Value is increment plus 32, space disables
// - Request with unmet increment resends last report
module trf_report_flow #(
    parameter int unsigned SCAN_CYC = `TRF_CLK_HZ / `TRF_SCAN_HZ,
    parameter int unsigned R110_CYC = `TRF_CLK_HZ / `TRF_RPS_110,
    parameter int unsigned R72_CYC  = `TRF_CLK_HZ / `TRF_RPS_72,
    parameter int unsigned R36_CYC  = `TRF_CLK_HZ / `TRF_RPS_36,
    parameter int unsigned R18_CYC  = `TRF_CLK_HZ / `TRF_RPS_18,
    parameter int unsigned R9_CYC   = `TRF_CLK_HZ / `TRF_RPS_9
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire trf_pkg::trf_tool_t tool_pins,
    input  wire logic              cmd_valid,
    input  wire logic [7:0]        cmd_data,
    output logic                   tx_valid,
    output logic [7:0]             tx_data,
    input  wire logic              tx_ready
);

    // Pin synchroniser stages and agreed value
    trf_pkg::trf_tool_t s1_q, s2_q, s3_q, tool_q;
    // Scan buffer: last in-range position, button, range
    logic [13:0]        smp_x_q, smp_y_q;
    logic [2:0]         btn_q;
    logic               prox_q;
    logic [31:0]        scan_cnt_q, rate_cnt_q;
    // Settings
    trf_pkg::trf_mode_t mode_q;
    logic [2:0]         rate_q;
    logic [6:0]         inc_q;
    logic               inc_arg_q;
    logic [2:0]         ctrl_q;
    // Issue state
    logic [13:0]        lst_x_q, lst_y_q;
    logic               pend_q, zf_q, busy_q;
    logic [2:0]         oop_q;
    logic [1:0]         idx_q;
    trf_pkg::trf_frame_t frm_q;
    // Bus slave
    logic               awready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]         bresp_q, rresp_q;
    logic [31:0]        rdata_q;
    logic               tx_valid_q;
    logic [7:0]         tx_data_q;

    // Decoded configuration
    trf_pkg::trf_cfg_t  cfg;
    assign cfg = trf_pkg::trf_cfg_t'(ctrl_q[1:0]);

    // Timebase ticks
    wire scan_tick = scan_cnt_q >= SCAN_CYC - 1;
    wire [31:0] rate_cyc = rate_q == `TRF_RATE_110 ? R110_CYC :
                           rate_q == `TRF_RATE_72  ? R72_CYC  :
                           rate_q == `TRF_RATE_36  ? R36_CYC  :
                           rate_q == `TRF_RATE_18  ? R18_CYC  : R9_CYC;
    wire rate_tick = rate_cnt_q >= rate_cyc - 1;

    // Command decode
    wire cmd_take = cmd_valid & ~inc_arg_q;
    wire arg_take = cmd_valid & inc_arg_q;
    wire arg_ok   = cmd_data >= `TRF_INC_LO && cmd_data <= `TRF_INC_HI;
    wire [7:0] arg_val = cmd_data - `TRF_INC_OFS;
    wire rst_cmd  = cmd_take && cmd_data == `TRF_CMD_RESET;
    wire trig     = cmd_take && cmd_data == `TRF_CMD_TRIG && mode_q == trf_pkg::MODE_REQUEST;

    // Reset defaults follow the configuration
    wire trf_pkg::trf_mode_t mode_def = cfg == trf_pkg::CFG_COMPAT1 ?
                                        trf_pkg::MODE_STREAM : trf_pkg::MODE_REQUEST;
    wire [2:0] rate_def = ctrl_q[`TRF_CTRL_ALT] ? `TRF_RATE_72 : `TRF_RATE_110;

    // Displacement from the last issued report, the square centre
    wire [14:0] dx  = {1'b0, smp_x_q} - {1'b0, lst_x_q};
    wire [14:0] dy  = {1'b0, smp_y_q} - {1'b0, lst_y_q};
    wire [14:0] adx = dx[14] ? 15'h0000 - dx : dx;
    wire [14:0] ady = dy[14] ? 15'h0000 - dy : dy;
    // Zero increment makes every sample meet the square
    wire met = adx >= {8'h00, inc_q} || ady >= {8'h00, inc_q};
    // Saturated seven-bit magnitudes
    wire [6:0] mag_x = |adx[14:7] ? 7'h7f : adx[6:0];
    wire [6:0] mag_y = |ady[14:7] ? 7'h7f : ady[6:0];

    // Button edges seen at scan time
    wire press   = scan_tick && btn_q == 3'h0 && tool_q.button != 3'h0;
    wire release_ev = scan_tick && btn_q != 3'h0 && tool_q.button == 3'h0;
    wire held    = btn_q != 3'h0;

    // Report requests per mode
    wire ev_point  = mode_q == trf_pkg::MODE_POINT && (press || release_ev);
    wire ev_stream = mode_q == trf_pkg::MODE_STREAM && rate_tick &&
                     (prox_q ? met : oop_q < `TRF_OOP_REP);
    wire ev_sw     = mode_q == trf_pkg::MODE_SWSTREAM &&
                     ((rate_tick && held && (met || !prox_q)) || press || release_ev);
    wire streaming = mode_q == trf_pkg::MODE_STREAM || mode_q == trf_pkg::MODE_SWSTREAM;
    wire ev        = ev_point || trig || ev_stream || ev_sw;
    wire zf_set    = mode_q == trf_pkg::MODE_SWSTREAM && release_ev;
    wire launch    = pend_q && !busy_q;
    // Unmet increment outside streaming repeats the old report
    wire fresh     = met || streaming;

    // Fresh frame encoding
    wire [2:0] flags  = zf_q ? 3'h0 : btn_q;
    wire prox_bit     = cfg == trf_pkg::CFG_COMPAT1 ? 1'b0 : !prox_q;
    trf_pkg::trf_frame_t new_frm, sel_frm;
    assign new_frm.b0 = {1'b1, prox_bit, 1'b0, !dx[14], !dy[14], flags};
    assign new_frm.b1 = {1'b0, mag_x};
    assign new_frm.b2 = {1'b0, mag_y};
    assign sel_frm    = fresh ? new_frm : frm_q;
    wire tx_fire      = tx_valid_q && tx_ready;
    wire [7:0] nxt_byte = idx_q == 2'h0 ? frm_q.b1 : frm_q.b2;

    // Absolute one-hot flags for status
    wire [3:0] onehot = (btn_q >= 3'h1 && btn_q <= 3'h4) ? 4'h1 << (btn_q - 3'h1) : 4'h0;

    // Register decode
    wire aw_go = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
    wire ar_go = s_axi_arvalid && !arready_q && !rvalid_q;
    wire wr_ctrl = aw_go && s_axi_awaddr == `TRF_CTRL_OFF && s_axi_wstrb[0];
    wire aw_map = s_axi_awaddr == `TRF_CTRL_OFF || s_axi_awaddr == `TRF_STAT_OFF;
    wire ar_map = s_axi_araddr == `TRF_CTRL_OFF || s_axi_araddr == `TRF_STAT_OFF;
    wire [31:0] stat = {14'h0000, busy_q, onehot, prox_q, inc_q, rate_q, mode_q};
    wire [31:0] rmux = s_axi_araddr == `TRF_CTRL_OFF ? {29'h0000_0000, ctrl_q} :
                       s_axi_araddr == `TRF_STAT_OFF ? stat : 32'h0000_0000;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            tool_q <= '0;
        end else begin
            s1_q <= tool_pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                tool_q <= s3_q;
            end
        end
    end

    // Scan and report-rate timebases
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scan_cnt_q <= 32'h0000_0000;
            rate_cnt_q <= 32'h0000_0000;
        end else begin
            scan_cnt_q <= scan_tick ? 32'h0000_0000 : scan_cnt_q + 32'h0000_0001;
            rate_cnt_q <= rate_tick ? 32'h0000_0000 : rate_cnt_q + 32'h0000_0001;
        end
    end

    // Scan buffer, filled whatever the mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            smp_x_q <= 14'h0000;
            smp_y_q <= 14'h0000;
            btn_q   <= 3'h0;
            prox_q  <= 1'b0;
        end else if (scan_tick) begin
            btn_q  <= tool_q.button;
            prox_q <= tool_q.in_range;
            // Out of range keeps the last in-range position
            if (tool_q.in_range) begin
                smp_x_q <= tool_q.x;
                smp_y_q <= tool_q.y;
            end
        end
    end

    // Mode and rate from host characters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= trf_pkg::MODE_REQUEST;
            rate_q <= `TRF_RATE_110;
        end else if (rst_cmd) begin
            mode_q <= mode_def;
            rate_q <= rate_def;
        end else if (cmd_take) begin
            case (cmd_data)
                `TRF_CMD_POINT:  mode_q <= trf_pkg::MODE_POINT;
                `TRF_CMD_REQ:    mode_q <= trf_pkg::MODE_REQUEST;
                `TRF_CMD_STREAM: mode_q <= trf_pkg::MODE_STREAM;
                `TRF_CMD_SWSTRM: mode_q <= trf_pkg::MODE_SWSTREAM;
                `TRF_CMD_R110:   rate_q <= `TRF_RATE_110;
                `TRF_CMD_R72:    rate_q <= `TRF_RATE_72;
                `TRF_CMD_R36:    rate_q <= `TRF_RATE_36;
                `TRF_CMD_R18:    rate_q <= `TRF_RATE_18;
                `TRF_CMD_R9:     rate_q <= `TRF_RATE_9;
                default:         mode_q <= mode_q;
            endcase
        end
    end

    // Increment command and its value character
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inc_q     <= 7'h00;
            inc_arg_q <= 1'b0;
        end else if (rst_cmd) begin
            inc_q     <= 7'h00;
            inc_arg_q <= 1'b0;
        end else if (arg_take) begin
            // Out-of-range value is dropped, setting unchanged
            inc_arg_q <= 1'b0;
            if (arg_ok) begin
                inc_q <= arg_val[6:0];
            end
        end else if (cmd_take && cmd_data == `TRF_CMD_INC) begin
            inc_arg_q <= 1'b1;
        end
    end

    // Pending request; a new request wins over the clear at launch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= 1'b0;
            zf_q   <= 1'b0;
        end else if (rst_cmd) begin
            pend_q <= 1'b0;
            zf_q   <= 1'b0;
        end else begin
            pend_q <= ev || (pend_q && !launch);
            zf_q   <= zf_set || (zf_q && !launch);
        end
    end

    // Square centre and out-of-range repeat count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lst_x_q <= 14'h0000;
            lst_y_q <= 14'h0000;
            oop_q   <= 3'h0;
        end else begin
            if (arg_take && arg_ok) begin
                // Enabling the filter centres it on the tool
                lst_x_q <= smp_x_q;
                lst_y_q <= smp_y_q;
            end else if (launch && fresh) begin
                lst_x_q <= smp_x_q;
                lst_y_q <= smp_y_q;
            end
            if (prox_q) begin
                oop_q <= 3'h0;
            end else if (launch && mode_q == trf_pkg::MODE_STREAM) begin
                oop_q <= oop_q + 3'h1;
            end
        end
    end

    // Byte sender; a frame never starts before the last one ends
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q     <= 1'b0;
            idx_q      <= 2'h0;
            frm_q      <= '0;
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
        end else if (launch) begin
            busy_q     <= 1'b1;
            idx_q      <= 2'h0;
            frm_q      <= sel_frm;
            tx_valid_q <= 1'b1;
            tx_data_q  <= sel_frm.b0;
        end else if (tx_fire) begin
            if (idx_q == 2'h2) begin
                busy_q     <= 1'b0;
                tx_valid_q <= 1'b0;
            end else begin
                idx_q     <= idx_q + 2'h1;
                tx_data_q <= nxt_byte;
            end
        end
    end

    // Write channel: address and data taken together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            ctrl_q    <= `TRF_CTRL_RST;
        end else begin
            awready_q <= aw_go;
            if (aw_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= aw_map ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (wr_ctrl) begin
                ctrl_q <= s_axi_wdata[2:0];
            end
        end
    end

    // Read channel, unmapped reads answer SLVERR with zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'h0;
            rdata_q   <= 32'h0000_0000;
        end else begin
            arready_q <= ar_go;
            if (ar_go) begin
                rvalid_q <= 1'b1;
                rresp_q  <= ar_map ? 2'h0 : 2'h2;
                rdata_q  <= rmux;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = awready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign tx_valid      = tx_valid_q;
    assign tx_data       = tx_data_q;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_phase;
        tx_valid_q && idx_q == 2'h0 |-> tx_data_q[7];
    endproperty
    a_phase: assert property (p_phase) else $error("first byte lacks sync bit");

    property p_msb;
        tx_valid_q && idx_q != 2'h0 |-> !tx_data_q[7];
    endproperty
    a_msb: assert property (p_msb) else $error("data byte msb set");

    property p_hold;
        tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q) && $stable(idx_q);
    endproperty
    a_hold: assert property (p_hold) else $error("byte changed before taken");

    property p_end;
        tx_fire && idx_q == 2'h2 |=> !tx_valid_q;
    endproperty
    a_end: assert property (p_end) else $error("frame ran past third byte");

    property p_rst_stream;
        rst_cmd && cfg == trf_pkg::CFG_COMPAT1 |=> mode_q == trf_pkg::MODE_STREAM;
    endproperty
    a_rst_stream: assert property (p_rst_stream) else $error("reset not to streaming");

    property p_rst_req;
        rst_cmd && cfg != trf_pkg::CFG_COMPAT1 |=> mode_q == trf_pkg::MODE_REQUEST;
    endproperty
    a_rst_req: assert property (p_rst_req) else $error("reset not to request");

    property p_trig;
        trig && !busy_q && !pend_q |-> ##2 tx_valid_q && idx_q == 2'h0;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger not answered");

    property p_noprox;
        launch && fresh && cfg == trf_pkg::CFG_COMPAT1 |=> !tx_data_q[6];
    endproperty
    a_noprox: assert property (p_noprox) else $error("proximity bit present");

    property p_oop;
        oop_q <= `TRF_OOP_REP;
    endproperty
    a_oop: assert property (p_oop) else $error("too many out-of-range repeats");

    property p_inc;
        arg_take && arg_ok && !rst_cmd |=> {1'b0, inc_q} == $past(arg_val);
    endproperty
    a_inc: assert property (p_inc) else $error("increment not offset by 32");

endmodule

/* File: sim/trf_host_model.sv */
/*
 Host model: takes report bytes from the transmitter byte port.
 Assumes one aclk domain and a valid/ready byte handshake.
*/
`timescale 1ns/1ns
module trf_host_model (
    input  wire logic           aclk,
    input  wire logic           aresetn,
    input  wire logic           slow,
    input  wire logic           tx_valid,
    input  wire logic [7:0]     tx_data,
    output logic                tx_ready,
    output trf_pkg::trf_frame_t frame_q,
    output int                  nframes_q
);
    logic [1:0] cnt_q; // Pacing count for a slow host
    logic [1:0] idx_q; // Next byte position
    // Slow host accepts one byte in four cycles
    assign tx_ready = !slow || (cnt_q == 2'h0);
    // Assemble frames; sync bit restarts, so a torn frame is never counted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q     <= 2'h0;
            idx_q     <= 2'h0;
            nframes_q <= 0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            if (tx_valid && tx_ready) begin
                if (tx_data[7]) begin
                    frame_q.b0 <= tx_data;
                    idx_q      <= 2'h1;
                end else if (idx_q == 2'h1) begin
                    frame_q.b1 <= tx_data;
                    idx_q      <= 2'h2;
                end else if (idx_q == 2'h2) begin
                    frame_q.b2 <= tx_data;
                    idx_q      <= 2'h0;
                    nframes_q  <= nframes_q + 1;
                end
            end
        end
    end
endmodule

/* File: sim/tb_trf_report_flow.sv */
/*
 Bench for the report flow block with short scan and rate counts.
 Assumes the host model above as transmitter sink.
*/
`timescale 1ns/1ns
`include "trf_defines.svh"
module tb_trf_report_flow;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, cmd_valid, tx_valid, tx_ready, slow;
    logic [7:0]          awaddr, araddr, cmd_data, tx_data;
    logic [31:0]         wdata, rdata, rd;
    logic [1:0]          bresp, rresp;
    logic [3:0]          wstrb;
    trf_pkg::trf_tool_t  tool;
    trf_pkg::trf_frame_t fr;
    int                  nf, c0, miscompares, n_checks;
    trf_report_flow #(.SCAN_CYC(50), .R110_CYC(40), .R72_CYC(60), .R36_CYC(120), .R18_CYC(240)
        ) i_trf_report_flow (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tool_pins(tool), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));
    trf_host_model i_trf_host_model (.aclk(aclk), .aresetn(aresetn), .slow(slow), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .frame_q(fr), .nframes_q(nf));
    // Clock, 4 ns period
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // Value compare
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task close_out;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // AXI write, response held until taken
    task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) begin
                awvalid <= 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk(bresp, er);
        @(posedge aclk);
    endtask
    // AXI read into rd
    task axr(input logic [7:0] a, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rready <= 1'b0;
        chk(rresp, er);
        @(posedge aclk);
    endtask
    // One host character, then a quiet cycle
    task cmd(input logic [7:0] c);
        cmd_valid <= 1'b1;
        cmd_data <= c;
        @(posedge aclk);
        cmd_valid <= 1'b0;
        @(posedge aclk);
    endtask
    // Trigger and wait for its frame
    task trig;
        c0 = nf;
        cmd(`TRF_CMD_TRIG);
        for (int i = 0; i < 100 && nf == c0; i++) @(posedge aclk);
        chk(nf - c0, 1);
    endtask
    // Reset defaults, then triggered relative reports
    task t_request;
        axr(`TRF_STAT_OFF, 2'h0);
        chk(rd[4:0], 5'h01);
        axr(8'h0c, 2'h2);
        chk(rd, 32'h0000_0000);
        tool <= '{1'b1, 3'h4, 14'h0064, 14'h0032};
        repeat (200) @(posedge aclk);
        trig();
        tool <= '{1'b1, 3'h2, 14'h0069, 14'h002f};
        repeat (120) @(posedge aclk);
        trig();
        chk(fr, 24'h92_0503);
        tool <= '{1'b0, 3'h2, 14'h00c8, 14'h0001};
        repeat (120) @(posedge aclk);
        trig();
        chk({fr.b0[7:3], fr.b1, fr.b2}, 21'h1b_0000);
    endtask
    // Config one: reset command defaults, streaming, out-of-range tail
    task t_stream;
        axw(`TRF_CTRL_OFF, 32'h0000_0005, 2'h0);
        // Write with no byte lanes must leave the control word alone
        wstrb <= 4'h0;
        axw(`TRF_CTRL_OFF, 32'h0000_0002, 2'h0);
        wstrb <= 4'hf;
        axw(8'h08, 32'h0000_0003, 2'h2);
        axr(`TRF_CTRL_OFF, 2'h0);
        chk(rd, 32'h0000_0005);
        tool <= '{1'b1, 3'h0, 14'h0100, 14'h0100};
        cmd(`TRF_CMD_RESET);
        axr(`TRF_STAT_OFF, 2'h0);
        chk(rd[4:0], 5'h06);
        slow <= 1'b1;
        c0 = nf;
        repeat (600) @(posedge aclk);
        chk((nf - c0) > 3, 1'b1);
        tool <= '{1'b0, 3'h0, 14'h0200, 14'h0200};
        c0 = nf;
        repeat (600) @(posedge aclk);
        chk((nf - c0) >= 4 && (nf - c0) <= 5, 1'b1);
        chk(fr.b0[6], 1'b0);
        c0 = nf;
        repeat (600) @(posedge aclk);
        chk(nf - c0, 0);
        slow <= 1'b0;
        cmd(`TRF_CMD_R36);
        axr(`TRF_STAT_OFF, 2'h0);
        chk(rd[4:2], `TRF_RATE_36);
    endtask
    // Point mode: one report on press, one on release
    task t_point;
        tool <= '{1'b1, 3'h0, 14'h0300, 14'h0300};
        cmd(`TRF_CMD_POINT);
        repeat (200) @(posedge aclk);
        c0 = nf;
        tool.button <= 3'h1;
        repeat (200) @(posedge aclk);
        chk(nf - c0, 1);
        chk(fr.b0[2:0], 3'h1);
        tool.button <= 3'h0;
        repeat (200) @(posedge aclk);
        chk(nf - c0, 2);
        chk(fr.b0[2:0], 3'h0);
    endtask
    // Increment filter in request mode, then switched streaming
    task t_filter_switch;
        cmd(`TRF_CMD_REQ);
        cmd(`TRF_CMD_INC);
        cmd(8'h2a);
        tool.x <= 14'h0305;
        repeat (120) @(posedge aclk);
        trig();
        chk(fr, 24'h98_0000);
        tool.x <= 14'h030a;
        repeat (120) @(posedge aclk);
        trig();
        chk(fr, 24'h98_0a00);
        axr(`TRF_STAT_OFF, 2'h0);
        chk(rd[11:5], 7'h0a);
        cmd(`TRF_CMD_INC);
        cmd(8'h20);
        cmd(`TRF_CMD_SWSTRM);
        cmd(`TRF_CMD_R110);
        axr(`TRF_STAT_OFF, 2'h0);
        chk(rd[11:0], 12'h003);
        c0 = nf;
        tool.button <= 3'h3;
        repeat (300) @(posedge aclk);
        chk((nf - c0) > 3, 1'b1);
        chk(fr.b0[2:0], 3'h3);
        c0 = nf;
        tool.button <= 3'h0;
        repeat (300) @(posedge aclk);
        chk((nf - c0) >= 1 && (nf - c0) <= 3, 1'b1);
        chk(fr.b0[2:0], 3'h0);
        c0 = nf;
        repeat (300) @(posedge aclk);
        chk(nf - c0, 0);
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        close_out();
    end
    // Main sequence
    initial begin
        miscompares = 0;
        n_checks = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, cmd_valid, slow} = 7'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hf;
        cmd_data = 8'h00;
        tool = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_request();
        t_stream();
        t_point();
        t_filter_switch();
        close_out();
    end
endmodule
